// *** common/wecu_pkg.sv ***
// constants and types shared by the wake and event capture unit
package wecu_pkg;

    // -------------------------------------------------------------
    // register access
    // -------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h4b;
    localparam logic [6:0] ADDR_GLOBAL = 7'h60;
    // group status registers sit at this base plus group index
    localparam logic [6:0] ADDR_STATUS_BASE = 7'h61;
    // capture enable registers sit at this base plus group index
    localparam logic [6:0] ADDR_ENABLE_BASE = 7'h4c;
    localparam int NUM_GROUPS = 4;

    // group index: system, supply, transceiver, local wake
    localparam int GRP_SYS = 0;
    localparam int GRP_SUP = 1;
    localparam int GRP_TRX = 2;
    localparam int GRP_WAKE = 3;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int LEVEL_BIT = 1;
    localparam int SYS_WATCHDOG_BIT = 0;
    localparam int SYS_SERIAL_BIT = 1;
    localparam int SYS_OVERTEMP_BIT = 2;
    localparam int SYS_POWER_ON_BIT = 4;
    localparam int SUP_MCU_UNDER_BIT = 0;
    localparam int SUP_UNDER_BIT = 1;
    localparam int SUP_OVER_BIT = 2;
    localparam int TRX_CAN_WAKE_BIT = 0;
    localparam int TRX_FAILURE_BIT = 1;
    localparam int TRX_SILENCE_BIT = 4;
    localparam int TRX_PN_ERROR_BIT = 5;
    localparam int WAKE_FALL_BIT = 0;
    localparam int WAKE_RISE_BIT = 1;

    // -------------------------------------------------------------
    // masks and reset values, index 3 first
    // -------------------------------------------------------------
    localparam logic [3:0][7:0] VALID_MASK = {8'h03, 8'h33, 8'h07, 8'h17};
    localparam logic [3:0][7:0] ALWAYS_MASK = {8'h00, 8'h20, 8'h00, 8'h11};
    localparam logic [3:0][7:0] REGULAR_MASK = {8'h03, 8'h01, 8'h00, 8'h00};
    localparam logic [3:0][7:0] STATUS_RST = {8'h00, 8'h00, 8'h00, 8'h10};
    localparam logic [3:0][7:0] ENABLE_RST = {8'h00, 8'h00, 8'h00, 8'h00};

    // -------------------------------------------------------------
    // mode control and timing
    // -------------------------------------------------------------
    localparam logic [2:0] MODE_CODE_SLEEP = 3'h1;
    localparam int TIMER_W = 16;
    localparam int DEFAULT_EVENT_DELAY_CYCLES = 500;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        WECU_MODE_NORMAL,
        WECU_MODE_STANDBY,
        WECU_MODE_SLEEP,
        WECU_MODE_RESET,
        WECU_MODE_OVERTEMP,
        WECU_MODE_OFF
    } wecu_mode_e;

endpackage

// *** core/wecu_top.sv ***
// wake and interrupt event capture unit
// Behaviour
// - rising or falling wake pin edge raises a wake event when its edge enable set
// - level register bit 1 shows wake pin level, other bits read zero
// - level valid in normal mode, elsewhere only with an edge enable set
// - power-on, watchdog and frame error events are always captured
// - all other events come up disabled; can and sensor supply events share the over and under enable bits
// - an event with its enable set sets its status bit
// - transceiver offline with mcu supply on: pending event pulls receive pin low
// - enabled event in sleep turns mcu supply on, via reset into standby
// - global status shows which event group has pending bits
// - writing 1 clears a status bit, 0 leaves it, many per write
// - clearing any set bit releases receive pin and starts the delay timer
// - events during delay still set bits; pending at expiry pulls pin low
// - all cleared before expiry leaves the receive pin high
// - status and enable registers readable at any time
// - delay timer stops at once on reset output falling edge
// - reset output low in reset, sleep, overtemp and off modes
// - entering sleep signals any pending event on the receive pin
// - can wake and wake edges are regular events, the rest diagnostic
// - sleep request with all regular events disabled triggers a system reset
// - sleep command with any event pending goes straight to reset mode
// - sleep disable bit set: sleep command raises serial failure, mode unchanged
// - each global group bit reads 1 while its group has a pending bit
`timescale 1ns/1ps
module wecu_top #(
    parameter int EVENT_DELAY_CYCLES = wecu_pkg::DEFAULT_EVENT_DELAY_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [wecu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [wecu_pkg::DATA_W-1:0] reg_wdata,
    output logic [wecu_pkg::DATA_W-1:0] reg_rdata,
    // device state
    input wire wecu_pkg::wecu_mode_e sys_mode,
    input wire logic can_offline,
    input wire logic sleep_disable_bit,
    // mode commands
    input wire logic mode_cmd_valid,
    input wire logic [2:0] mode_code,
    // event sources, one-cycle pulses
    input wire logic power_on_event,
    input wire logic overtemp_warning_event,
    input wire logic serial_failure_event,
    input wire logic watchdog_failure_event,
    input wire logic can_supply_over_event,
    input wire logic sensor_supply_over_event,
    input wire logic can_supply_under_event,
    input wire logic sensor_supply_under_event,
    input wire logic mcu_supply_under_event,
    input wire logic can_bus_wakeup_event,
    input wire logic partial_net_frame_error,
    input wire logic bus_silence_event,
    input wire logic transceiver_failure_event,
    // local wake pin
    input wire logic wake_pin,
    // outputs to pins and mode control
    output logic rxd_force_low,
    output logic reset_output_n,
    output logic mode_sleep_go,
    output logic mode_reset_go,
    output logic wake_supply_on
);

    // -------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------
    // delay as cycles
    if (EVENT_DELAY_CYCLES < 1 || EVENT_DELAY_CYCLES >= (1 << wecu_pkg::TIMER_W)) begin : g_chk
        $error("event delay out of range");
    end
    localparam logic [wecu_pkg::TIMER_W-1:0] DELAY_LOAD = wecu_pkg::TIMER_W'(EVENT_DELAY_CYCLES);
    logic wake_level;
    logic local_rise_event;
    logic local_fall_event;
    logic [3:0][7:0] status_reg;
    logic [3:0][7:0] status_next;
    logic [3:0][7:0] enable_reg;
    logic [3:0][7:0] enable_next;
    logic [3:0][7:0] enable_eff;
    logic [3:0][7:0] event_raw;
    logic [3:0][7:0] event_cap;
    logic [3:0][7:0] clear_mask;
    logic [3:0] group_pending;
    logic [wecu_pkg::TIMER_W-1:0] timer_reg;
    logic [wecu_pkg::TIMER_W-1:0] timer_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rxd_reg, rxd_next;
    logic reset_output_n_reg, reset_output_n_next;
    logic sleep_go_reg, sleep_go_next;
    logic reset_go_reg, reset_go_next;
    logic supply_on_reg, supply_on_next;
    logic clear_any, pending, pending_next, sleep_cmd, regular_enabled, mcu_on;

    // -------------------------------------------------------------
    // wake pin front end
    // -------------------------------------------------------------
    wecu_wake_sync u_wake_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wake_pin(wake_pin),
        .level(wake_level),
        .rise_pulse(local_rise_event),
        .fall_pulse(local_fall_event)
    );

    // -------------------------------------------------------------
    // event gathering
    // -------------------------------------------------------------
    // sleep command decode; a sleep refused by the disable bit counts as serial failure
    assign sleep_cmd = mode_cmd_valid && (mode_code == wecu_pkg::MODE_CODE_SLEEP);
    assign mcu_on = (sys_mode == wecu_pkg::WECU_MODE_NORMAL) ||
                    (sys_mode == wecu_pkg::WECU_MODE_STANDBY);

    always_comb begin
        event_raw = '0;
        event_raw[wecu_pkg::GRP_SYS][wecu_pkg::SYS_POWER_ON_BIT] = power_on_event;
        event_raw[wecu_pkg::GRP_SYS][wecu_pkg::SYS_OVERTEMP_BIT] = overtemp_warning_event;
        event_raw[wecu_pkg::GRP_SYS][wecu_pkg::SYS_SERIAL_BIT] =
            serial_failure_event | (sleep_cmd & sleep_disable_bit);
        event_raw[wecu_pkg::GRP_SYS][wecu_pkg::SYS_WATCHDOG_BIT] = watchdog_failure_event;
        event_raw[wecu_pkg::GRP_SUP][wecu_pkg::SUP_OVER_BIT] =
            can_supply_over_event | sensor_supply_over_event;
        event_raw[wecu_pkg::GRP_SUP][wecu_pkg::SUP_UNDER_BIT] =
            can_supply_under_event | sensor_supply_under_event;
        event_raw[wecu_pkg::GRP_SUP][wecu_pkg::SUP_MCU_UNDER_BIT] = mcu_supply_under_event;
        event_raw[wecu_pkg::GRP_TRX][wecu_pkg::TRX_CAN_WAKE_BIT] = can_bus_wakeup_event;
        event_raw[wecu_pkg::GRP_TRX][wecu_pkg::TRX_FAILURE_BIT] = transceiver_failure_event;
        event_raw[wecu_pkg::GRP_TRX][wecu_pkg::TRX_SILENCE_BIT] = bus_silence_event;
        event_raw[wecu_pkg::GRP_TRX][wecu_pkg::TRX_PN_ERROR_BIT] = partial_net_frame_error;
        event_raw[wecu_pkg::GRP_WAKE][wecu_pkg::WAKE_RISE_BIT] = local_rise_event;
        event_raw[wecu_pkg::GRP_WAKE][wecu_pkg::WAKE_FALL_BIT] = local_fall_event;
    end

    // -------------------------------------------------------------
    // status and enable bits
    // -------------------------------------------------------------
    // per-bit capture: a set in the clearing cycle wins, so no event is lost
    for (genvar g = 0; g < wecu_pkg::NUM_GROUPS; g++) begin : g_grp
        assign clear_mask[g] = (reg_wr_en && reg_addr == wecu_pkg::ADDR_STATUS_BASE +
                                wecu_pkg::ADDR_W'(g)) ? reg_wdata : 8'h00;
        assign enable_next[g] = (reg_wr_en && reg_addr == wecu_pkg::ADDR_ENABLE_BASE +
                                 wecu_pkg::ADDR_W'(g)) ?
                                (reg_wdata & wecu_pkg::VALID_MASK[g]) : enable_reg[g];
        assign enable_eff[g] = enable_reg[g] | wecu_pkg::ALWAYS_MASK[g];
        for (genvar b = 0; b < 8; b++) begin : g_bit
            assign event_cap[g][b] = event_raw[g][b] & enable_eff[g][b];
            assign status_next[g][b] = wecu_pkg::VALID_MASK[g][b] &
                (event_cap[g][b] | (status_reg[g][b] & ~clear_mask[g][b]));
        end
        assign group_pending[g] = |status_reg[g];
    end

    // a clear counts only if it drops a set bit
    assign clear_any = |(status_reg & clear_mask);
    assign pending = |group_pending;
    assign pending_next = |status_next;
    // regular events are can wake and wake edges
    assign regular_enabled = |(enable_reg & wecu_pkg::REGULAR_MASK);

    // status and enables; enables come up cleared
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= wecu_pkg::STATUS_RST;
            enable_reg <= wecu_pkg::ENABLE_RST;
        end else begin
            status_reg <= status_next;
            enable_reg <= enable_next;
        end
    end

    // -------------------------------------------------------------
    // delay timer, receive pin and mode control
    // -------------------------------------------------------------
    always_comb begin
        // only normal and standby keep reset output high
        reset_output_n_next = mcu_on;
        // counts down to zero and rests there
        timer_next = (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
        if (clear_any) begin
            timer_next = DELAY_LOAD;
        end
        // reset output fall stops the timer
        if (reset_output_n_reg && !reset_output_n_next) begin
            timer_next = '0;
        end
        // low again at expiry when pending
        rxd_next = pending_next && (timer_next == '0) &&
                   ((can_offline && mcu_on) || sys_mode == wecu_pkg::WECU_MODE_SLEEP);
        // enabled event in sleep wakes the supply
        supply_on_next = (sys_mode == wecu_pkg::WECU_MODE_SLEEP) && (|event_cap);
        sleep_go_next = 1'b0;
        reset_go_next = 1'b0;
        // refusal order: disabled sleep, pending events, no regular wake source
        if (sleep_cmd && !sleep_disable_bit) begin
            reset_go_next = pending || !regular_enabled;
            sleep_go_next = !reset_go_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_reg <= '0;
            rxd_reg <= 1'b0;
            reset_output_n_reg <= 1'b0;
            sleep_go_reg <= 1'b0;
            reset_go_reg <= 1'b0;
            supply_on_reg <= 1'b0;
        end else begin
            timer_reg <= timer_next;
            rxd_reg <= rxd_next;
            reset_output_n_reg <= reset_output_n_next;
            sleep_go_reg <= sleep_go_next;
            reset_go_reg <= reset_go_next;
            supply_on_reg <= supply_on_next;
        end
    end

    // -------------------------------------------------------------
    // register read
    // -------------------------------------------------------------
    // reads never wait on the timer
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_en) begin
            rdata_next = 8'h00;
            if (reg_addr == wecu_pkg::ADDR_WAKE_LEVEL) begin
                rdata_next[wecu_pkg::LEVEL_BIT] = wake_level &&
                    (sys_mode == wecu_pkg::WECU_MODE_NORMAL ||
                     |enable_reg[wecu_pkg::GRP_WAKE]);
            end else if (reg_addr == wecu_pkg::ADDR_GLOBAL) begin
                rdata_next = {4'h0, group_pending};
            end
            for (int g = 0; g < wecu_pkg::NUM_GROUPS; g++) begin
                if (reg_addr == wecu_pkg::ADDR_STATUS_BASE + wecu_pkg::ADDR_W'(g)) begin
                    rdata_next = status_reg[g];
                end
                if (reg_addr == wecu_pkg::ADDR_ENABLE_BASE + wecu_pkg::ADDR_W'(g)) begin
                    rdata_next = enable_reg[g];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign rxd_force_low = rxd_reg;
    assign reset_output_n = reset_output_n_reg;
    assign mode_sleep_go = sleep_go_reg;
    assign mode_reset_go = reset_go_reg;
    assign wake_supply_on = supply_on_reg;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_RISE_CAPTURE:
        assert property (local_rise_event && enable_reg[3][1] |=> status_reg[3][1])
        else $error("enabled rising wake edge not captured");
    AST_LEVEL_READ:
        assert property (reg_rd_en && reg_addr == 7'h4b && sys_mode == wecu_pkg::WECU_MODE_NORMAL
                         |=> reg_rdata == {6'h00, $past(wake_level), 1'b0})
        else $error("wake level read wrong");
    AST_LEVEL_MASK:
        assert property (reg_rd_en && reg_addr == 7'h4b && enable_reg[3] == 8'h00 &&
                         sys_mode != wecu_pkg::WECU_MODE_NORMAL |=> reg_rdata == 8'h00)
        else $error("wake level shown while not valid");
    AST_ALWAYS_CAPTURE: assert property (watchdog_failure_event |=> status_reg[0][0])
        else $error("watchdog failure not captured");
    AST_DISABLED_IGNORED:
        assert property (overtemp_warning_event && !enable_reg[0][2] && !status_reg[0][2]
                         |=> !status_reg[0][2])
        else $error("disabled event captured");
    AST_CLEAR_ONE:
        assert property (reg_wr_en && reg_addr == 7'h61 && reg_wdata[4] &&
                         !power_on_event |=> !status_reg[0][4])
        else $error("write one did not clear");
    AST_CLEAR_RELEASE:
        assert property (clear_any && (reset_output_n_next || !reset_output_n_reg)
                         |=> !rxd_force_low && timer_reg == DELAY_LOAD)
        else $error("clear did not release pin and load timer");
    AST_EXPIRE_LOW:
        assert property (timer_reg == 16'h0001 && !clear_any && pending && can_offline &&
                         mcu_on && reset_output_n_reg == reset_output_n_next |=> rxd_force_low)
        else $error("pending event not signalled at expiry");
    AST_HOLD_DURING_DELAY:
        assert property (timer_reg > 16'h0001 && (reset_output_n_next || !reset_output_n_reg) |=> !rxd_force_low)
        else $error("pin pulled low while delay runs");
    AST_TIMER_STOP:
        assert property (reset_output_n_reg && !mcu_on |=> timer_reg == 16'h0000 && !reset_output_n)
        else $error("timer not stopped on reset output fall");
    AST_SLEEP_PENDING:
        assert property (sleep_cmd && !sleep_disable_bit && pending
                         |=> mode_reset_go && !mode_sleep_go)
        else $error("sleep taken with event pending");
    AST_SLEEP_NO_REGULAR:
        assert property (sleep_cmd && !sleep_disable_bit && !regular_enabled |=> mode_reset_go)
        else $error("sleep taken with no wake source");
    AST_SLEEP_DISABLED:
        assert property (sleep_cmd && sleep_disable_bit && enable_reg[0][1]
                         |=> status_reg[0][1] && !mode_sleep_go && !mode_reset_go)
        else $error("disabled sleep not refused");
    AST_SLEEP_WAKE:
        assert property (sys_mode == wecu_pkg::WECU_MODE_SLEEP && can_bus_wakeup_event &&
                         enable_reg[2][0] |=> wake_supply_on)
        else $error("sleep wake did not turn supply on");
    AST_GLOBAL_READ:
        assert property (reg_rd_en && reg_addr == 7'h60 |=> reg_rdata[3] == $past(group_pending[3]))
        else $error("global wake group bit wrong");
    COV_CLEAR_DURING_DELAY: cover property (timer_reg != '0 && clear_any);
    COV_EXPIRE_PENDING: cover property (timer_reg == 16'h0001 ##1 rxd_force_low);
    COV_SLEEP_GRANTED: cover property (mode_sleep_go);
    COV_SLEEP_WAKE: cover property (wake_supply_on);
endmodule

// *** core/wecu_wake_sync.sv ***
// local wake pin synchroniser, level filter and edge detector
`timescale 1ns/1ps
module wecu_wake_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // raw pin
    input wire logic wake_pin,
    // filtered level and edge pulses
    output logic level,
    output logic rise_pulse,
    output logic fall_pulse
);

    logic [wecu_pkg::SYNC_STAGES-1:0] sync_reg;
    logic [wecu_pkg::SYNC_STAGES-1:0] sync_next;
    logic level_reg;
    logic level_next;
    logic rise_reg;
    logic rise_next;
    logic fall_reg;
    logic fall_next;

    // -------------------------------------------------------------
    // synchroniser and filter
    // -------------------------------------------------------------
    // first stage feeds only the second; the level moves once stages two and three agree
    always_comb begin
        sync_next = {sync_reg[wecu_pkg::SYNC_STAGES-2:0], wake_pin};
        level_next = level_reg;
        if (sync_reg[1] == sync_reg[2]) begin
            level_next = sync_reg[2];
        end
        rise_next = level_next & ~level_reg;
        fall_next = ~level_next & level_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg <= '0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            level_reg <= level_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign level = level_reg;
    assign rise_pulse = rise_reg;
    assign fall_pulse = fall_reg;

endmodule

// *** verif/tb.sv ***
// self-checking testbench of the wake and event capture unit
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, rst_b = 1'b0, rd_en, wr_en, ofl = 1'b1, sdis = 1'b0, mcv = 1'b0;
    logic [6:0] addr;
    logic [7:0] wd, rdat, v, en;
    logic [2:0] mc = 3'h0;
    logic [12:0] ev = 13'h0;
    logic wk = 1'b0, rxd, rsto, slp, rgo, sup;
    wecu_pkg::wecu_mode_e md = wecu_pkg::WECU_MODE_STANDBY;
    int fail_count = 0, comparisons = 0, cyc = 0;
    always #50 ref_clk = ~ref_clk;
    wecu_host_model i_host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_wdata(wd), .reg_rdata(rdat));
    wecu_top #(.EVENT_DELAY_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(addr), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_wdata(wd),
        .reg_rdata(rdat), .sys_mode(md), .can_offline(ofl), .sleep_disable_bit(sdis),
        .mode_cmd_valid(mcv), .mode_code(mc), .power_on_event(ev[0]),
        .overtemp_warning_event(ev[1]), .serial_failure_event(ev[2]),
        .watchdog_failure_event(ev[3]), .can_supply_over_event(ev[4]),
        .sensor_supply_over_event(ev[5]), .can_supply_under_event(ev[6]),
        .sensor_supply_under_event(ev[7]), .mcu_supply_under_event(ev[8]),
        .can_bus_wakeup_event(ev[9]), .partial_net_frame_error(ev[10]),
        .bus_silence_event(ev[11]), .transceiver_failure_event(ev[12]), .wake_pin(wk),
        .rxd_force_low(rxd), .reset_output_n(rsto), .mode_sleep_go(slp),
        .mode_reset_go(rgo), .wake_supply_on(sup));
    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        chk(v, exp);
    endtask
    // expected status: a fired event shows only where its enable is set
    function automatic logic [7:0] cap_exp(input logic [7:0] ena, input logic [7:0] fired);
        return ena & fired;
    endfunction
    // pulse one event line, or issue one mode command
    task automatic pulse(input int i);
        @(negedge ref_clk);
        ev[i] = 1'b1;
        @(negedge ref_clk);
        ev[i] = 1'b0;
    endtask
    task automatic cmd(input logic [2:0] c = wecu_pkg::MODE_CODE_SLEEP);
        @(negedge ref_clk);
        mcv = 1'b1;
        mc = c;
        @(negedge ref_clk);
        mcv = 1'b0;
    endtask
    // bounded run time
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h35b1));
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        rdchk(7'h61, 8'h10);
        rdchk(7'h60, 8'h01);
        chk({7'h0, rxd}, 8'h01);
        cmd();
        chk({6'h0, slp, rgo}, 8'h01);
        i_host.service();
        chk({7'h0, rxd}, 8'h00);
        rdchk(7'h61, 8'h00);
        cmd();
        chk({6'h0, slp, rgo}, 8'h01);
        pulse(9);
        pulse(1);
        pulse(3);
        rdchk(7'h63, 8'h00);
        rdchk(7'h61, 8'h01);
        i_host.service();
        for (int k = 0; k < 4; k++) begin
            en = 8'($urandom) & 8'h07;
            i_host.wr(7'h4d, en);
            ev[8:4] = 5'h1f;
            @(negedge ref_clk);
            ev[8:4] = 5'h00;
            rdchk(7'h62, cap_exp(en, 8'h07));
            rdchk(7'h60, {6'h0, |cap_exp(en, 8'h07), 1'b0});
            i_host.service();
        end
        md = wecu_pkg::WECU_MODE_NORMAL;
        i_host.wr(7'h4f, 8'h03);
        wk = 1'b1;
        repeat (10) @(negedge ref_clk);
        rdchk(7'h64, 8'h02);
        rdchk(7'h4b, 8'h02);
        i_host.wr(7'h4e, 8'h01);
        pulse(9);
        i_host.wr(7'h64, 8'h02);
        chk({7'h0, rxd}, 8'h00);
        rdchk(7'h63, 8'h01);
        repeat (6) @(negedge ref_clk);
        chk({7'h0, rxd}, 8'h01);
        i_host.service();
        repeat (8) @(negedge ref_clk);
        chk({7'h0, rxd}, 8'h00);
        cmd();
        chk({6'h0, slp, rgo}, 8'h02);
        sdis = 1'b1;
        i_host.wr(7'h4c, 8'h02);
        cmd();
        chk({6'h0, slp, rgo}, 8'h00);
        rdchk(7'h61, 8'h02);
        cmd(3'($urandom) | 3'h2);
        chk({6'h0, slp, rgo}, 8'h00);
        // standby with edge enables off, then sleep entered while the delay runs
        md = wecu_pkg::WECU_MODE_STANDBY;
        i_host.wr(7'h4f, 8'h00);
        rdchk(7'h4b, 8'h00);
        i_host.wr(7'h61, 8'h02);
        pulse(9);
        chk({7'h0, rxd}, 8'h00);
        md = wecu_pkg::WECU_MODE_SLEEP;
        @(negedge ref_clk);
        chk({7'h0, rsto}, 8'h00);
        chk({7'h0, rxd}, 8'h01);
        pulse(9);
        chk({7'h0, sup}, 8'h01);
        rdchk(7'h4e, 8'h01);
        complete_run();
    end
endmodule

// *** verif/wecu_host_model.sv ***
// host model: register port driver that polls and clears event flags
`timescale 1ns/1ps
module wecu_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [6:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 7'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
    end
    // one write, strobe held for one edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~d; // stale data must not be trusted
    endtask
    // one read, data taken one cycle after the strobe edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask
    task automatic service();
        logic [7:0] g;
        logic [7:0] s;
        rd(7'h60, g);
        for (int i = 0; i < 4; i++) begin
            if (g[i]) begin
                rd(7'h61 + 7'(i), s);
                wr(7'h61 + 7'(i), s);
            end
        end
    endtask
endmodule
